/* File: src/status_alarm_register_bank.sv */
// Status and alarm register bank: readbacks, temperature, sync and alarms.
// Assumes all event inputs are one-cycle pulses synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
`include "status_alarm_cfg.svh"

module status_alarm_register_bank #(
   parameter int LANES = 2,
   parameter int LIMIT_W = 16
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic softReset,
   // Serial control port
   input wire logic sclk,
   input wire logic csN,
   input wire logic mosi,
   output logic miso,
   output logic misoOe,
   // Fast reconfiguration interface captures
   input wire logic frTxnDone,
   input wire logic frSelectFlag,
   input wire logic frAccumWrite,
   input wire logic [3:0] frAccumField,
   // Temperature sensor
   input wire logic [7:0] sensorCode,
   input wire logic sensorCodeValid,
   output logic sensorSleep,
   // Synchronization events
   input wire logic dividerRealign,
   input wire logic refCheckDone,
   input wire logic refPhaseMatch,
   input wire logic oscSyncEvent,
   input wire logic refPulseSeen,
   // Serial link status
   input wire logic serialLinkEnable,
   input wire logic linkUp,
   input wire logic [LIMIT_W-1:0] linkTimeoutLimit,
   input wire logic coding64b66b,
   input wire logic [LANES-1:0] laneEnable,
   input wire logic [LANES-1:0] laneCrcFault,
   input wire logic dividerMisalign,
   input wire logic linkMisalign,
   // Alarm pin
   output logic alarmOut
);

   generate
      if (LANES < 1 || LANES > 8) begin : g_bad_lanes
         $error("status_alarm_register_bank: LANES out of range");
      end
   endgenerate

   // ****************************************
   // Reset release
   // ****************************************
   // Async assert, release through two flops to avoid recovery hazards
   logic rstMeta_q, rstSync_q;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rstMeta_q <= 1'b0;
         rstSync_q <= 1'b0;
      end else begin
         rstMeta_q <= 1'b1;
         rstSync_q <= rstMeta_q;
      end
   end

   // ****************************************
   // Functions
   // ****************************************
   // Write-one-to-clear with set priority
   function automatic status_alarm_pkg::reg_byte_t sticky_next(
      input status_alarm_pkg::reg_byte_t cur,
      input status_alarm_pkg::reg_byte_t setBits,
      input status_alarm_pkg::reg_byte_t clrBits
   );
      sticky_next = (cur & ~clrBits) | setBits;
   endfunction : sticky_next

   // Address match for a write strobe
   function automatic logic hit(
      input logic [14:0] addr,
      input logic [14:0] ofs
   );
      hit = (addr == ofs);
   endfunction : hit

   // ****************************************
   // Serial port and link supervision
   // ****************************************
   logic [14:0] regAddr;
   logic [7:0] regWrData;
   logic regWrite;
   status_alarm_pkg::reg_byte_t readData;
   logic linkLostPulse, timeoutPulse;
   logic chipClear;

   assign chipClear = softReset;

   serial_reg_port u_port (
      .clk(clk),
      .rstSync_n(rstSync_q),
      .sclk(sclk),
      .csN(csN),
      .mosi(mosi),
      .rdData(readData),
      .miso(miso),
      .misoOe(misoOe),
      .regAddr(regAddr),
      .regWrData(regWrData),
      .regWrite(regWrite)
   );

   link_watch #(
      .LIMIT_W(LIMIT_W)
   ) u_link (
      .clk(clk),
      .rstSync_n(rstSync_q),
      .chipClear(chipClear),
      .linkUp(linkUp),
      .linkEnable(serialLinkEnable),
      .timeoutLimit(linkTimeoutLimit),
      .linkLostPulse(linkLostPulse),
      .timeoutPulse(timeoutPulse)
   );

   // ****************************************
   // Reconfiguration readbacks
   // ****************************************
   // Captured without synchronization; software reads only while idle
   logic selectFlag_q, selectFlag_d;
   logic [3:0] accumField_q, accumField_d;

   always_comb begin
      selectFlag_d = selectFlag_q;
      accumField_d = accumField_q;
      if (frTxnDone) begin
         selectFlag_d = frSelectFlag;
      end
      if (frAccumWrite) begin
         accumField_d = frAccumField;
      end
   end

   always_ff @(posedge clk or negedge rstSync_q) begin
      if (!rstSync_q) begin
         selectFlag_q <= 1'b0;
         accumField_q <= 4'h0;
      end else begin
         selectFlag_q <= selectFlag_d;
         accumField_q <= accumField_d;
      end
   end

   // ****************************************
   // Temperature sensor and sleep control
   // ****************************************
   // Reading is dropped to zero while asleep so stale codes never look valid
   status_alarm_pkg::reg_byte_t sleepReg_q, sleepReg_d;
   status_alarm_pkg::reg_byte_t tempReading_q, tempReading_d;
   logic sensorSleep_q, sensorSleep_d;

   always_comb begin
      sleepReg_d = sleepReg_q;
      tempReading_d = tempReading_q;
      if (chipClear) begin
         sleepReg_d = `SLEEP_RESET;
      end else if (regWrite && hit(regAddr, `OFS_SENSOR_SLEEP)) begin
         sleepReg_d = regWrData;
      end
      sensorSleep_d = sleepReg_d[`SLEEP_BIT];
      if (sleepReg_q[`SLEEP_BIT] || chipClear) begin
         tempReading_d = 8'h00;
      end else if (sensorCodeValid) begin
         tempReading_d = sensorCode;
      end
   end

   always_ff @(posedge clk or negedge rstSync_q) begin
      if (!rstSync_q) begin
         sleepReg_q <= `SLEEP_RESET;
         tempReading_q <= 8'h00;
         sensorSleep_q <= 1'b0;
      end else begin
         sleepReg_q <= sleepReg_d;
         tempReading_q <= tempReading_d;
         sensorSleep_q <= sensorSleep_d;
      end
   end

   // ****************************************
   // Synchronization status
   // ****************************************
   // Sticky bits 3,1,0 plus a live consistency bit that writes cannot touch
   logic [3:0] syncSticky_q, syncSticky_d;
   logic consistent_q, consistent_d;
   status_alarm_pkg::reg_byte_t syncSet, syncClr, syncNext;

   always_comb begin
      syncSet = 8'h00;
      syncSet[`SYNC_REALIGN_BIT] = dividerRealign;
      syncSet[`SYNC_OSC_BIT] = oscSyncEvent;
      syncSet[`SYNC_REF_BIT] = refPulseSeen;
      syncClr = 8'h00;
      if (regWrite && hit(regAddr, `OFS_SYNC_STATUS)) begin
         syncClr = regWrData & 8'h0B;
      end
      if (chipClear) begin
         syncClr = 8'hFF;
         syncSet = 8'h00;
      end
      syncNext = sticky_next({4'h0, syncSticky_q}, syncSet, syncClr);
      syncSticky_d = syncNext[3:0];
      syncSticky_d[`SYNC_CONSISTENT_BIT] = 1'b0;
      consistent_d = consistent_q;
      if (chipClear) begin
         consistent_d = 1'b0;
      end else if (refCheckDone) begin
         consistent_d = refPhaseMatch;
      end
   end

   always_ff @(posedge clk or negedge rstSync_q) begin
      if (!rstSync_q) begin
         syncSticky_q <= 4'h0;
         consistent_q <= 1'b0;
      end else begin
         syncSticky_q <= syncSticky_d;
         consistent_q <= consistent_d;
      end
   end

   // ****************************************
   // System alarms
   // ****************************************
   // Chip reset alarm rises one cycle after any reset, once flags are clear
   status_alarm_pkg::reg_byte_t alarms_q, alarms_d;
   status_alarm_pkg::reg_byte_t alarmSet, alarmClr;
   logic resetDone_q, resetDone_d;
   logic crcEvent, misalignEvent;

   always_comb begin
      crcEvent = coding64b66b & |(laneCrcFault & laneEnable);
      misalignEvent = dividerMisalign | (linkMisalign & serialLinkEnable);
      resetDone_d = ~chipClear;
      alarmSet = 8'h00;
      alarmSet[`ALM_LINK_LOST_BIT] = linkLostPulse;
      alarmSet[`ALM_TIMEOUT_BIT] = timeoutPulse;
      alarmSet[`ALM_CRC_BIT] = crcEvent;
      alarmSet[`ALM_CHIP_RESET_BIT] = ~resetDone_q;
      alarmSet[`ALM_MISALIGN_BIT] = misalignEvent;
      alarmClr = 8'h00;
      if (regWrite && hit(regAddr, `OFS_SYSTEM_ALARMS)) begin
         alarmClr = regWrData;
      end
      if (chipClear) begin
         alarmClr = 8'hFF;
         alarmSet = 8'h00;
      end
      alarms_d = sticky_next(alarms_q, alarmSet, alarmClr) & `ALARM_USED;
   end

   always_ff @(posedge clk or negedge rstSync_q) begin
      if (!rstSync_q) begin
         alarms_q <= 8'h00;
         resetDone_q <= 1'b0;
      end else begin
         alarms_q <= alarms_d;
         resetDone_q <= resetDone_d;
      end
   end

   // ****************************************
   // Alarm mask and alarm pin
   // ****************************************
   // Chip reset alarm is kept off the pin so boot does not assert it
   status_alarm_pkg::reg_byte_t mask_q, mask_d;
   logic alarmOut_q, alarmOut_d;

   always_comb begin
      mask_d = mask_q;
      if (chipClear) begin
         mask_d = `MASK_RESET;
      end else if (regWrite && hit(regAddr, `OFS_ALARM_MASK)) begin
         mask_d = regWrData & `MASK_USED;
      end
      alarmOut_d = |(alarms_q & ~mask_q & `ALARM_PIN_BITS);
   end

   always_ff @(posedge clk or negedge rstSync_q) begin
      if (!rstSync_q) begin
         mask_q <= `MASK_RESET;
         alarmOut_q <= 1'b0;
      end else begin
         mask_q <= mask_d;
         alarmOut_q <= alarmOut_d;
      end
   end

   // ****************************************
   // Read decode
   // ****************************************
   // Unmapped and reserved locations read zero
   always_comb begin
      readData = 8'h00;
      unique case (regAddr)
         `OFS_SELECT_READBACK: readData[`SELECT_FLAG_BIT] = selectFlag_q;
         `OFS_ACCUM_READBACK: readData = {4'h0, accumField_q};
         `OFS_TEMPERATURE: readData = tempReading_q;
         `OFS_SENSOR_SLEEP: readData = sleepReg_q;
         `OFS_SYNC_STATUS: readData = {4'h0, syncSticky_q[3],
            consistent_q, syncSticky_q[1:0]};
         `OFS_SYSTEM_ALARMS: readData = alarms_q;
         `OFS_ALARM_MASK: readData = mask_q;
         default: readData = 8'h00;
      endcase
   end

   assign sensorSleep = sensorSleep_q;
   assign alarmOut = alarmOut_q;

endmodule : status_alarm_register_bank

`default_nettype wire

/* File: include/status_alarm_cfg.svh */
// Offsets, field positions, reset values and frame counts of the status bank.
// Assumes a 15-bit register address carried by the serial control port.
`ifndef STATUS_ALARM_CFG_SVH
`define STATUS_ALARM_CFG_SVH

// ****************************************
// Register offsets
// ****************************************
`define OFS_SELECT_READBACK 15'h03E0
`define OFS_ACCUM_READBACK 15'h03E1
`define OFS_TEMPERATURE 15'h0400
`define OFS_SENSOR_SLEEP 15'h0401
`define OFS_SYNC_STATUS 15'h0410
`define OFS_SYSTEM_ALARMS 15'h0430
`define OFS_ALARM_MASK 15'h0431

// ****************************************
// Field positions
// ****************************************
`define SELECT_FLAG_BIT 7
`define SLEEP_BIT 0
`define SYNC_REALIGN_BIT 3
`define SYNC_CONSISTENT_BIT 2
`define SYNC_OSC_BIT 1
`define SYNC_REF_BIT 0
`define ALM_LINK_LOST_BIT 7
`define ALM_TIMEOUT_BIT 6
`define ALM_CRC_BIT 5
`define ALM_CHIP_RESET_BIT 1
`define ALM_MISALIGN_BIT 0

// ****************************************
// Reset values and used-bit masks
// ****************************************
`define SLEEP_RESET 8'h00
`define MASK_RESET 8'h00
`define MASK_USED 8'hE1
`define ALARM_USED 8'hE3
`define ALARM_PIN_BITS 8'hE1
`define ACCUM_USED 8'h0F

// ****************************************
// Serial frame counts
// ****************************************
`define FRAME_BITS 5'd24
`define HEADER_BITS 5'd16

`endif

/* File: include/status_alarm_pkg.sv */
// Types shared by the status bank and its serial port.
// Assumes nothing beyond a SystemVerilog package scope.
package status_alarm_pkg;

   // Serial port frame phase
   typedef enum logic [1:0] {
      PORT_IDLE = 2'b00,
      PORT_HEADER = 2'b01,
      PORT_DATA = 2'b10
   } port_state_t;

   typedef logic [7:0] reg_byte_t;

endpackage : status_alarm_pkg

/* File: src/link_watch.sv */
// Serial link supervision: link-lost edge and link-down timeout events.
// Assumes link status inputs are synchronous to clk.
`timescale 1ns/1ps
`default_nettype none

module link_watch #(
   parameter int LIMIT_W = 16
) (
   input wire logic clk,
   input wire logic rstSync_n,
   input wire logic chipClear,
   input wire logic linkUp,
   input wire logic linkEnable,
   input wire logic [LIMIT_W-1:0] timeoutLimit,
   output logic linkLostPulse,
   output logic timeoutPulse
);

   generate
      if (LIMIT_W < 1 || LIMIT_W > 31) begin : g_bad_width
         $error("link_watch: LIMIT_W out of range");
      end
   endgenerate

   logic linkUpPrev_q, linkUpPrev_d;
   logic [LIMIT_W:0] downCount_q, downCount_d;
   logic lost_q, lost_d;
   logic expired_q, expired_d;

   // ****************************************
   // Edge and timeout detection
   // ****************************************
   // Count saturates one past the limit so the event fires exactly once
   always_comb begin
      linkUpPrev_d = linkUp;
      lost_d = linkUpPrev_q & ~linkUp & linkEnable;
      downCount_d = downCount_q;
      expired_d = 1'b0;
      if (linkUp || !linkEnable || chipClear) begin
         downCount_d = '0;
      end else if (downCount_q <= {1'b0, timeoutLimit}) begin
         downCount_d = downCount_q + 1'b1;
         expired_d = (downCount_q == {1'b0, timeoutLimit});
      end
   end

   always_ff @(posedge clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         linkUpPrev_q <= 1'b0;
         downCount_q <= '0;
         lost_q <= 1'b0;
         expired_q <= 1'b0;
      end else begin
         linkUpPrev_q <= linkUpPrev_d;
         downCount_q <= downCount_d;
         lost_q <= lost_d;
         expired_q <= expired_d;
      end
   end

   assign linkLostPulse = lost_q;
   assign timeoutPulse = expired_q;

endmodule : link_watch

`default_nettype wire

/* File: src/serial_reg_port.sv */
// Serial control port slave: 24-bit frames, read flag, 15-bit address, 8 data.
// Assumes sclk, csN and mosi are synchronous to clk, each sclk level >= 2 clk.
`timescale 1ns/1ps
`default_nettype none
`include "status_alarm_cfg.svh"

module serial_reg_port (
   input wire logic clk,
   input wire logic rstSync_n,
   input wire logic sclk,
   input wire logic csN,
   input wire logic mosi,
   input wire logic [7:0] rdData,
   output logic miso,
   output logic misoOe,
   output logic [14:0] regAddr,
   output logic [7:0] regWrData,
   output logic regWrite
);

   status_alarm_pkg::port_state_t state_q, state_d;
   logic sclkPrev_q, sclkPrev_d;
   logic [4:0] bitCount_q, bitCount_d;
   logic [15:0] shift_q, shift_d;
   logic isRead_q, isRead_d;
   logic loadRead_q, loadRead_d;
   logic [7:0] outShift_q, outShift_d;
   logic miso_q, miso_d;
   logic misoOe_q, misoOe_d;
   logic [14:0] addr_q, addr_d;
   logic [7:0] wrData_q, wrData_d;
   logic write_q, write_d;
   logic rise, fall;

   // ****************************************
   // Frame sequencing
   // ****************************************
   // Read data is driven from the 16th rising edge; shifts on later falls
   always_comb begin
      rise = ~csN & sclk & ~sclkPrev_q;
      fall = ~csN & ~sclk & sclkPrev_q;
      sclkPrev_d = sclk;
      state_d = state_q;
      bitCount_d = bitCount_q;
      shift_d = shift_q;
      isRead_d = isRead_q;
      loadRead_d = 1'b0;
      outShift_d = outShift_q;
      miso_d = miso_q;
      misoOe_d = misoOe_q;
      addr_d = addr_q;
      wrData_d = wrData_q;
      write_d = 1'b0;
      if (csN) begin
         state_d = status_alarm_pkg::PORT_IDLE;
         bitCount_d = 5'd0;
         misoOe_d = 1'b0;
         miso_d = 1'b0;
      end else begin
         unique case (state_q)
            status_alarm_pkg::PORT_IDLE: begin
               state_d = status_alarm_pkg::PORT_HEADER;
            end
            status_alarm_pkg::PORT_HEADER: begin
               if (rise) begin
                  shift_d = {shift_q[14:0], mosi};
                  bitCount_d = bitCount_q + 5'd1;
                  if (bitCount_q == `HEADER_BITS - 5'd1) begin
                     state_d = status_alarm_pkg::PORT_DATA;
                     isRead_d = shift_q[14];
                     addr_d = {shift_q[13:0], mosi};
                     loadRead_d = shift_q[14];
                  end
               end
            end
            status_alarm_pkg::PORT_DATA: begin
               if (loadRead_q) begin
                  miso_d = rdData[7];
                  outShift_d = {rdData[6:0], 1'b0};
                  misoOe_d = 1'b1;
               end else if (fall && isRead_q && bitCount_q > `HEADER_BITS) begin
                  miso_d = outShift_q[7];
                  outShift_d = {outShift_q[6:0], 1'b0};
               end
               if (rise && bitCount_q < `FRAME_BITS) begin
                  shift_d = {shift_q[14:0], mosi};
                  bitCount_d = bitCount_q + 5'd1;
                  if (bitCount_q == `FRAME_BITS - 5'd1 && !isRead_q) begin
                     wrData_d = {shift_q[6:0], mosi};
                     write_d = 1'b1;
                  end
               end
            end
            default: begin
               state_d = status_alarm_pkg::PORT_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         state_q <= status_alarm_pkg::PORT_IDLE;
         sclkPrev_q <= 1'b0;
         bitCount_q <= 5'd0;
         shift_q <= 16'h0000;
         isRead_q <= 1'b0;
         loadRead_q <= 1'b0;
         outShift_q <= 8'h00;
         miso_q <= 1'b0;
         misoOe_q <= 1'b0;
         addr_q <= 15'h0000;
         wrData_q <= 8'h00;
         write_q <= 1'b0;
      end else begin
         state_q <= state_d;
         sclkPrev_q <= sclkPrev_d;
         bitCount_q <= bitCount_d;
         shift_q <= shift_d;
         isRead_q <= isRead_d;
         loadRead_q <= loadRead_d;
         outShift_q <= outShift_d;
         miso_q <= miso_d;
         misoOe_q <= misoOe_d;
         addr_q <= addr_d;
         wrData_q <= wrData_d;
         write_q <= write_d;
      end
   end

   assign miso = miso_q;
   assign misoOe = misoOe_q;
   assign regAddr = addr_q;
   assign regWrData = wrData_q;
   assign regWrite = write_q;

endmodule : serial_reg_port

`default_nettype wire

/* File: test/status_alarm_props.sv */
// Concurrent checks on the status bank's alarm pin and sensor sleep output.
// Assumes it is bound to status_alarm_register_bank and sees its ports only.
`timescale 1ns/1ps
`default_nettype none

module status_alarm_props #(
   parameter int LANES = 2
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic softReset,
   input wire logic csN,
   input wire logic sensorSleep,
   input wire logic alarmOut,
   input wire logic serialLinkEnable,
   input wire logic linkUp,
   input wire logic coding64b66b,
   input wire logic [LANES-1:0] laneEnable,
   input wire logic [LANES-1:0] laneCrcFault,
   input wire logic dividerMisalign,
   input wire logic linkMisalign
);
   // ****************
   // Properties
   // ****************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   // No alarm source active; link disabled so no timeout can mature
   wire logic quiet;
   assign quiet = !dividerMisalign && !linkMisalign && !(|laneCrcFault) && !serialLinkEnable;

   property p_rst_pin;
      $rose(reset_n) |-> !alarmOut ##1 !alarmOut;
   endproperty
   a_rst_pin: assert property (p_rst_pin) else $error("alarm pin high after reset");
   property p_soft_pin;
      softReset && quiet ##1 quiet [*3] |-> !alarmOut;
   endproperty
   a_soft_pin: assert property (p_soft_pin) else $error("alarm pin kept over reset");
   property p_sleep_clr;
      softReset |-> ##2 !sensorSleep;
   endproperty
   a_sleep_clr: assert property (p_sleep_clr) else $error("sleep not cleared");
   // Pin may only drop after a frame write or a chip reset
   property p_fall_src;
      $fell(alarmOut) |-> $past(softReset, 2) || $past(csN, 3) == 1'b0;
   endproperty
   a_fall_src: assert property (p_fall_src) else $error("alarm pin dropped alone");
   property p_div_mis;
      softReset ##2 dividerMisalign |-> ##[1:4] alarmOut;
   endproperty
   a_div_mis: assert property (p_div_mis) else $error("divider misalign lost");
   property p_link_mis;
      softReset ##2 (linkMisalign && serialLinkEnable) |-> ##[1:4] alarmOut;
   endproperty
   a_link_mis: assert property (p_link_mis) else $error("link misalign lost");
   property p_crc;
      softReset ##2 (coding64b66b && |(laneEnable & laneCrcFault)) |-> ##[1:4] alarmOut;
   endproperty
   a_crc: assert property (p_crc) else $error("lane crc fault lost");
   property p_lost;
      softReset ##2 (serialLinkEnable && $fell(linkUp)) |-> ##[1:5] alarmOut;
   endproperty
   a_lost: assert property (p_lost) else $error("link loss lost");

   // Main scenarios reached
   c_fall: cover property ($fell(alarmOut));
   c_sleep: cover property ($rose(sensorSleep));
   c_div: cover property (softReset ##2 dividerMisalign);
endmodule : status_alarm_props

bind status_alarm_register_bank status_alarm_props #(.LANES(LANES)) u_props (
   .clk(clk),
   .reset_n(reset_n),
   .softReset(softReset),
   .csN(csN),
   .sensorSleep(sensorSleep),
   .alarmOut(alarmOut),
   .serialLinkEnable(serialLinkEnable),
   .linkUp(linkUp),
   .coding64b66b(coding64b66b),
   .laneEnable(laneEnable),
   .laneCrcFault(laneCrcFault),
   .dividerMisalign(dividerMisalign),
   .linkMisalign(linkMisalign)
);

`default_nettype wire

/* File: test/testbench.sv */
// Self-checking bench for the status bank, driven through its serial port.
// Assumes the bank's header and package are on the include path.
`timescale 1ns/1ps
`default_nettype none
`include "status_alarm_cfg.svh"

module testbench;
   logic clk, reset_n, softReset, sclk, csN, mosi, miso, misoOe, sensorSleep, alarmOut;
   logic frTxnDone, frSelectFlag, frAccumWrite, sensorCodeValid, refPhaseMatch;
   logic dividerRealign, refCheckDone, oscSyncEvent, refPulseSeen, coding64b66b;
   logic serialLinkEnable, linkUp, dividerMisalign, linkMisalign;
   logic [3:0] frAccumField;
   logic [7:0] sensorCode;
   logic [15:0] linkTimeoutLimit;
   logic [1:0] laneEnable, laneCrcFault;
   int seed, n_errors, checked, r;
   int expTab[6] = '{1, 1, 32, 128, 0, 0};

   status_alarm_register_bank #(.LANES(2), .LIMIT_W(16)) dut (.clk(clk), .reset_n(reset_n),
      .softReset(softReset), .sclk(sclk), .csN(csN), .mosi(mosi), .miso(miso),
      .misoOe(misoOe), .frTxnDone(frTxnDone), .frSelectFlag(frSelectFlag),
      .frAccumWrite(frAccumWrite), .frAccumField(frAccumField), .sensorCode(sensorCode),
      .sensorCodeValid(sensorCodeValid), .sensorSleep(sensorSleep),
      .dividerRealign(dividerRealign), .refCheckDone(refCheckDone),
      .refPhaseMatch(refPhaseMatch), .oscSyncEvent(oscSyncEvent),
      .refPulseSeen(refPulseSeen), .serialLinkEnable(serialLinkEnable), .linkUp(linkUp),
      .linkTimeoutLimit(linkTimeoutLimit), .coding64b66b(coding64b66b),
      .laneEnable(laneEnable), .laneCrcFault(laneCrcFault),
      .dividerMisalign(dividerMisalign), .linkMisalign(linkMisalign), .alarmOut(alarmOut));

   // ****************
   // Tasks
   // ****************
   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask : tick

   task automatic cmp(input logic [7:0] g, input logic [7:0] e);
      checked++;
      if (g !== e) begin
         n_errors++;
         $display("MISMATCH %0t got %h expected %h", $time, g, e);
      end
   endtask : cmp

   // One 24-bit frame; four clocks per serial level keeps the port's sampler happy
   task automatic frame(input logic rd, input logic [14:0] a, input logic [7:0] d,
         output logic [7:0] q);
      logic [23:0] w;
      w = {rd, a, d};
      q = 8'h00;
      csN = 1'b0;
      for (int i = 23; i >= 0; i--) begin
         mosi = w[i];
         tick(4);
         if (i < 8) q[i] = miso;
         if (i == 7) cmp({7'h00, misoOe}, {7'h00, rd});
         sclk = 1'b1;
         tick(4);
         sclk = 1'b0;
      end
      csN = 1'b1;
      tick(6);
   endtask : frame

   task automatic wr(input logic [14:0] a, input logic [7:0] d);
      logic [7:0] q;
      frame(1'b0, a, d, q);
   endtask : wr

   task automatic rd(input logic [14:0] a, input logic [7:0] e);
      logic [7:0] q;
      frame(1'b1, a, 8'h00, q);
      cmp(q, e);
   endtask : rd

   task automatic finish_test;
      if (n_errors == 0 && checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : finish_test

   // ****************
   // Clock and hang guard
   // ****************
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   initial begin
      repeat (100000) @(posedge clk);
      n_errors++;
      finish_test();
   end

   // ****************
   // Scenarios
   // ****************
   initial begin
      seed = 98245;
      {reset_n, softReset, sclk, mosi, frTxnDone, frSelectFlag, frAccumWrite} = '0;
      {sensorCodeValid, refPhaseMatch, dividerRealign, refCheckDone, oscSyncEvent} = '0;
      {refPulseSeen, coding64b66b, serialLinkEnable, dividerMisalign, linkMisalign} = '0;
      {frAccumField, sensorCode, laneCrcFault} = '0;
      csN = 1'b1;
      linkUp = 1'b1;
      laneEnable = 2'b10;
      linkTimeoutLimit = 16'hFFFF;
      tick(20);
      reset_n = 1'b1;
      tick(5);
      rd(`OFS_SYSTEM_ALARMS, 8'h02);
      rd(`OFS_ALARM_MASK, 8'h00);
      rd(`OFS_SENSOR_SLEEP, 8'h00);
      wr(`OFS_SYSTEM_ALARMS, 8'h1C);
      rd(`OFS_SYSTEM_ALARMS, 8'h02);
      wr(`OFS_SYSTEM_ALARMS, 8'hFF);
      rd(`OFS_SYSTEM_ALARMS, 8'h00);
      // Readbacks and temperature from one random draw
      r = $random(seed);
      {frSelectFlag, frTxnDone, frAccumWrite, sensorCodeValid} = 4'hF;
      frAccumField = r[3:0];
      sensorCode = r[11:4];
      tick(1);
      {frSelectFlag, frTxnDone, frAccumWrite, sensorCodeValid} = 4'h0;
      rd(`OFS_SELECT_READBACK, 8'h80);
      rd(`OFS_ACCUM_READBACK, {4'h0, r[3:0]});
      rd(`OFS_TEMPERATURE, r[11:4]);
      wr(`OFS_SENSOR_SLEEP, 8'hFF);
      cmp({7'h00, sensorSleep}, 8'h01);
      rd(`OFS_SENSOR_SLEEP, 8'hFF);
      rd(`OFS_TEMPERATURE, 8'h00);
      // Sync flags, then a clear racing a new pulse
      {dividerRealign, oscSyncEvent, refPulseSeen, refCheckDone, refPhaseMatch} = 5'h1F;
      tick(1);
      {dividerRealign, oscSyncEvent, refPulseSeen, refCheckDone, refPhaseMatch} = 5'h00;
      rd(`OFS_SYNC_STATUS, 8'h0F);
      wr(`OFS_SYNC_STATUS, 8'h00);
      rd(`OFS_SYNC_STATUS, 8'h0F);
      wr(`OFS_SYNC_STATUS, 8'hFF);
      rd(`OFS_SYNC_STATUS, 8'h04);
      refPulseSeen = 1'b1;
      wr(`OFS_SYNC_STATUS, 8'h01);
      refPulseSeen = 1'b0;
      rd(`OFS_SYNC_STATUS, 8'h05);
      // Each alarm source but timeout after a chip reset, plus two that must not count
      for (int k = 0; k < 6; k++) begin
         softReset = 1'b1;
         tick(1);
         softReset = 1'b0;
         tick(1);
         case (k)
            0: dividerMisalign = 1'b1;
            1: {serialLinkEnable, linkMisalign} = 2'b11;
            2: {coding64b66b, laneCrcFault} = 3'b110;
            3: {serialLinkEnable, linkUp} = 2'b10;
            4: linkMisalign = 1'b1;
            default: laneCrcFault = 2'b10;
         endcase
         tick(2);
         {dividerMisalign, linkMisalign, laneCrcFault, coding64b66b, serialLinkEnable} = '0;
         linkUp = 1'b1;
         tick(4);
         cmp({7'h00, alarmOut}, {7'h00, expTab[k] != 0});
         rd(`OFS_SYSTEM_ALARMS, 8'h02 | expTab[k][7:0]);
      end
      rd(`OFS_SENSOR_SLEEP, 8'h00);
      // Link down past a short limit
      linkTimeoutLimit = 16'h0004;
      {serialLinkEnable, linkUp} = 2'b10;
      tick(12);
      {serialLinkEnable, linkUp} = 2'b01;
      rd(`OFS_SYSTEM_ALARMS, 8'hC2);
      wr(`OFS_SYSTEM_ALARMS, 8'hC0);
      cmp({7'h00, alarmOut}, 8'h00);
      wr(`OFS_ALARM_MASK, 8'hFF);
      rd(`OFS_ALARM_MASK, 8'hE1);
      dividerMisalign = 1'b1;
      tick(1);
      dividerMisalign = 1'b0;
      tick(4);
      cmp({7'h00, alarmOut}, 8'h00);
      rd(`OFS_SYSTEM_ALARMS, 8'h03);
      rd(15'h0123, 8'h00);
      softReset = 1'b1;
      tick(1);
      softReset = 1'b0;
      tick(6);
      rd(`OFS_ALARM_MASK, 8'h00);
      rd(`OFS_SYSTEM_ALARMS, 8'h02);
      finish_test();
   end
endmodule : testbench

`default_nettype wire
